// *** standby_guard_pkg.sv ***
/*
  Shared constants for the standby subsystem reset guard: timing, register
  offsets, field positions, reset values and the sequencer state encoding.
  Assumes a single system clock at the rate given by CLK_PERIOD_NS.
*/
`default_nettype none
package standby_guard_pkg;

  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS        = 100;
  // Least time the subsystem stays in reset, rounded up to whole cycles.
  localparam int SUBSYS_RESET_TIME_NS = 2000;
  localparam int SUBSYS_RESET_CYCLES  = (SUBSYS_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Period of the repeated reset toward the memory test unit, rounded down.
  localparam int MTU_PERIOD_NS        = 10000;
  localparam int MTU_PERIOD_CYCLES    = MTU_PERIOD_NS / CLK_PERIOD_NS;

  // Counter width shared by both timers.
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] SUBSYS_RESET_LAST = CNT_W'(SUBSYS_RESET_CYCLES - 1);
  localparam logic [CNT_W-1:0] MTU_PERIOD_LAST   = CNT_W'(MTU_PERIOD_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO          = 8'h00;

  // Bus and memory geometry.
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;
  localparam int RAM_AW = 8;
  localparam int RAM_DW = 32;

  // Register byte offsets.
  localparam logic [REG_AW-1:0] CONTROL_OFS       = 8'h00;
  localparam logic [REG_AW-1:0] STATUS_OFS        = 8'h04;
  localparam logic [REG_AW-1:0] EVENT_OFS         = 8'h08;
  localparam logic [REG_AW-1:0] MASK_OFS          = 8'h0c;
  localparam logic [REG_AW-1:0] SHARED_ECC_OFS    = 8'h10;
  localparam logic [REG_AW-1:0] INTERNAL_ECC_OFS  = 8'h14;
  localparam logic [REG_AW-1:0] ALARM_OFS         = 8'h18;

  // Control field positions and value after reset.
  localparam int CTL_POWER_BIT = 0;
  localparam int CTL_WAKE_BIT  = 1;
  localparam int CTL_ECC_BIT   = 2;
  localparam logic [2:0] CONTROL_RST = 3'h3;

  // Event field positions; event and mask share this layout.
  localparam int EV_RESET_BIT = 0;
  localparam int EV_WAKE_BIT  = 1;
  localparam int EV_ECC_BIT   = 2;
  localparam logic [2:0] EVENT_RST = 3'h0;
  localparam logic [2:0] MASK_RST  = 3'h0;

  // ECC flag layout: bit 0 single-bit error, bit 1 uncorrectable error.
  localparam int ECC_SBE_BIT = 0;
  localparam int ECC_DBE_BIT = 1;
  localparam logic [1:0] ECC_FLAGS_RST = 2'h0;

  // Subsystem reset sequencer states, one-hot.
  typedef enum logic [2:0]
  {
    SEQ_IDLE = 3'b001,
    SEQ_RUN  = 3'b010,
    SEQ_DONE = 3'b100
  } seq_state_type;

endpackage
`default_nettype wire

// *** shared_ram_store.sv ***
/*
  Storage array of the shared data RAM with a registered read port.
  Assumes the caller gates the write enable and asks for blank reads.
*/
`timescale 1ns/1ps
`default_nettype none
module shared_ram_store
(
  // Clock, reset and enable.
  input  wire logic                                 mclk,
  input  wire logic                                 rst,
  input  wire logic                                 ce,
  // Access port.
  input  wire logic                                 we,
  input  wire logic                                 re,
  input  wire logic                                 blank,
  input  wire logic [standby_guard_pkg::RAM_AW-1:0] addr,
  input  wire logic [standby_guard_pkg::RAM_DW-1:0] wdata,
  output logic      [standby_guard_pkg::RAM_DW-1:0] rdata
);
  import standby_guard_pkg::*;

  // The array has no reset, so contents survive every reset like real RAM.
  logic [RAM_DW-1:0] mem [0:(1<<RAM_AW)-1];

  // Write port.
  always_ff @(posedge mclk)
  begin
    if (ce && we)
    begin
      mem[addr] <= wdata;
    end
  end

  // Read port; a blank read loads zero so no stored word leaks out.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= '0;
    end
    else if (ce && re)
    begin
      rdata <= blank ? '0 : mem[addr];
    end
  end

endmodule
`default_nettype wire

// *** subsys_reset_sequencer.sv ***
/*
  Sequencer that holds the standby controller in reset for a fixed time.
  Assumes start is a synchronous request; it is ignored unless idle.
*/
`timescale 1ns/1ps
`default_nettype none
module subsys_reset_sequencer
(
  // Clock, reset and enable.
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // Request and state.
  input  wire logic start,
  output logic      begin_pulse,
  output logic      active
);
  import standby_guard_pkg::*;

  seq_state_type          state_r;  // Current state.
  seq_state_type          state_nxt; // Next state.
  logic [CNT_W-1:0]       cnt_r;    // Cycles left in reset.

  // A reset begins only from idle; a start while busy is absorbed.
  assign begin_pulse = ce && start && (state_r == SEQ_IDLE);
  assign active      = (state_r == SEQ_RUN);

  // Next-state decision.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SEQ_IDLE:
      begin
        if (start)
        begin
          state_nxt = SEQ_RUN;
        end
      end
      SEQ_RUN:
      begin
        if (cnt_r == CNT_ZERO)
        begin
          state_nxt = SEQ_DONE;
        end
      end
      SEQ_DONE:
      begin
        state_nxt = SEQ_IDLE;
      end
      default:
      begin
        state_nxt = SEQ_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= SEQ_IDLE;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
    end
  end

  // Reset length counter, loaded as the reset begins.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= CNT_ZERO;
    end
    else if (ce)
    begin
      if (begin_pulse)
      begin
        cnt_r <= SUBSYS_RESET_LAST;
      end
      else if (state_r == SEQ_RUN && cnt_r != CNT_ZERO)
      begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // A begun reset is executing from the next cycle on.
  a_seq_enter: assert property (@(posedge mclk) disable iff (rst)
    begin_pulse |=> active)
    else $error("Subsystem reset did not start after begin.");

endmodule
`default_nettype wire

// *** standby_ram_reset_guard.sv ***
/*
  Reset guard between host access to the shared data RAM and the standby
  controller's reset, wake and ECC reset controls, with the RAM ECC flag
  registers. Assumes one clock, synchronous inputs and pulse-wide requests
  for application, system and warm power-on resets; rst is the cold reset.
*/
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module standby_ram_reset_guard
(
  // Clock, reset and enable.
  input  wire logic                                 mclk,
  input  wire logic                                 rst,
  input  wire logic                                 ce,
  // Register port.
  input  wire logic [standby_guard_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [standby_guard_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [standby_guard_pkg::REG_DW-1:0] reg_rdata,
  // Host port to the shared data RAM.
  input  wire logic [standby_guard_pkg::RAM_AW-1:0] ram_addr,
  input  wire logic [standby_guard_pkg::RAM_DW-1:0] ram_wdata,
  input  wire logic                                 ram_wr,
  input  wire logic                                 ram_rd,
  output logic      [standby_guard_pkg::RAM_DW-1:0] ram_rdata,
  // Requests from the standby controller and the reset system.
  input  wire logic                                 ctrl_reset_req,
  input  wire logic                                 ctrl_wake_req,
  input  wire logic                                 app_reset_req,
  input  wire logic                                 sys_reset_req,
  input  wire logic                                 warm_por_req,
  // ECC error events from the two RAMs.
  input  wire logic [1:0]                           shared_ecc_evt,
  input  wire logic [1:0]                           internal_ecc_evt,
  // Status toward the system.
  output logic                                      subsys_reset_active,
  output logic                                      wake_accept,
  output logic                                      mtu_reset,
  output logic                                      alarm_shared,
  output logic                                      alarm_internal,
  output logic                                      irq
);
  import standby_guard_pkg::*;

  // Clear-by-zero update of a two-bit ECC flag field; the event wins.
  function automatic logic [1:0] flag_update(input logic [1:0] old_v, input logic wr,
                                             input logic [1:0] wv, input logic [1:0] evt);
    logic [1:0] kept;
    kept = wr ? (old_v & wv) : old_v;
    flag_update = kept | evt;
  endfunction

  logic [2:0]        control_r;      // Power enable, wake permit, ECC reset permit.
  logic [2:0]        event_r;        // Sticky events, cleared by writing one.
  logic [2:0]        mask_r;         // Interrupt mask, same layout as events.
  logic [1:0]        shared_flags_r; // Shared RAM ECC flags.
  logic [1:0]        internal_flags_r; // Controller internal RAM ECC flags.
  logic              pend_r;         // ECC reset trigger waiting for service.
  logic [CNT_W-1:0]  mtu_cnt_r;      // Spacing of repeated memory test resets.
  logic              wake_r;         // Registered wake acceptance pulse.
  logic              mtu_r;          // Registered memory test reset pulse.
  logic [REG_DW-1:0] rdata_r;        // Register read data.
  logic              begin_pulse;    // A subsystem reset begins this cycle.
  logic              seq_start;      // Request to begin a subsystem reset.
  logic              soft_rst;       // Application, system or warm reset.
  logic              pend_set;       // An uncorrectable error raises a trigger.
  logic              wake_take;      // A wake request is accepted.
  logic              mem_we;         // Gated write enable into the RAM.
  logic              wr_control;     // Register write decodes.
  logic              wr_event;
  logic              wr_mask;
  logic              wr_shared;
  logic              wr_internal;
  logic              power_enable;   // Named control fields.
  logic              wake_permit;
  logic              ecc_permit;

  assign power_enable = control_r[CTL_POWER_BIT];
  assign wake_permit  = control_r[CTL_WAKE_BIT];
  assign ecc_permit   = control_r[CTL_ECC_BIT];

  // Write decodes; each register is one aligned word.
  assign wr_control  = reg_wr && (reg_addr == CONTROL_OFS);
  assign wr_event    = reg_wr && (reg_addr == EVENT_OFS);
  assign wr_mask     = reg_wr && (reg_addr == MASK_OFS);
  assign wr_shared   = reg_wr && (reg_addr == SHARED_ECC_OFS);
  assign wr_internal = reg_wr && (reg_addr == INTERNAL_ECC_OFS);

  assign soft_rst = app_reset_req || sys_reset_req || warm_por_req;

  // Every subsystem reset source is gated by the power enable, so a
  // disabled controller can never reset itself or the shared RAM path.
  assign seq_start = power_enable && (ctrl_reset_req || soft_rst || pend_r);

  // Only an uncorrectable shared RAM error with the permit set arms a trigger.
  assign pend_set = ce && shared_ecc_evt[ECC_DBE_BIT] && ecc_permit;

  // Wake requests need both the wake permit and a powered controller.
  assign wake_take = ce && ctrl_wake_req && wake_permit && power_enable;

  // Writes arriving while the controller is in reset never reach the array.
  assign mem_we = ram_wr && !subsys_reset_active;

  // Subsystem reset sequencer.
  subsys_reset_sequencer u_seq
  (
    .mclk        (mclk),
    .rst         (rst),
    .ce          (ce),
    .start       (seq_start),
    .begin_pulse (begin_pulse),
    .active      (subsys_reset_active)
  );

  // Shared data RAM; a read during reset is answered with zero.
  shared_ram_store u_ram
  (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .we    (mem_we),
    .re    (ram_rd),
    .blank (subsys_reset_active),
    .addr  (ram_addr),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );

  // Control register; a soft reset restores it, and a beginning subsystem
  // reset drops the ECC reset permit so a later error cannot loop resets.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      control_r <= CONTROL_RST;
    end
    else if (ce)
    begin
      if (soft_rst)
      begin
        control_r <= CONTROL_RST;
      end
      else if (begin_pulse)
      begin
        control_r[CTL_ECC_BIT] <= 1'b0;
      end
      else if (wr_control)
      begin
        control_r <= reg_wdata[2:0];
      end
    end
  end

  // Pending ECC trigger; any begun subsystem reset services it, and a new
  // error in the same cycle keeps it pending.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pend_r <= 1'b0;
    end
    else if (ce)
    begin
      pend_r <= pend_set || (pend_r && !begin_pulse);
    end
  end

  // Repeated memory test reset while a trigger waits; the first pulse comes
  // one cycle after arming, then once per period.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mtu_cnt_r <= CNT_ZERO;
      mtu_r     <= 1'b0;
    end
    else if (ce)
    begin
      if (!pend_r)
      begin
        mtu_cnt_r <= CNT_ZERO;
        mtu_r     <= 1'b0;
      end
      else if (mtu_cnt_r == CNT_ZERO)
      begin
        mtu_cnt_r <= MTU_PERIOD_LAST;
        mtu_r     <= 1'b1;
      end
      else
      begin
        mtu_cnt_r <= mtu_cnt_r - 8'h01;
        mtu_r     <= 1'b0;
      end
    end
  end

  // Wake acceptance pulse.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wake_r <= 1'b0;
    end
    else if (ce)
    begin
      wake_r <= wake_take;
    end
  end

  // Sticky events; a set in the cycle of a clearing write wins.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      event_r <= EVENT_RST;
    end
    else if (ce)
    begin
      event_r[EV_RESET_BIT] <= begin_pulse ||
                               (event_r[EV_RESET_BIT] && !(wr_event && reg_wdata[EV_RESET_BIT]));
      event_r[EV_WAKE_BIT]  <= wake_take ||
                               (event_r[EV_WAKE_BIT] && !(wr_event && reg_wdata[EV_WAKE_BIT]));
      event_r[EV_ECC_BIT]   <= (pend_set && !pend_r) ||
                               (event_r[EV_ECC_BIT] && !(wr_event && reg_wdata[EV_ECC_BIT]));
    end
  end

  // Interrupt mask.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mask_r <= MASK_RST;
    end
    else if (ce && wr_mask)
    begin
      mask_r <= reg_wdata[2:0];
    end
  end

  // Shared RAM ECC flags are cleared by the cold reset only; soft and warm
  // resets leave them, so software must clear them by writing zero.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      shared_flags_r <= ECC_FLAGS_RST;
    end
    else if (ce)
    begin
      shared_flags_r <= flag_update(shared_flags_r, wr_shared, reg_wdata[1:0],
                                    shared_ecc_evt);
    end
  end

  // Internal RAM ECC flags survive application and system resets but a
  // warm reset clears them; a new error in that cycle is still kept.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      internal_flags_r <= ECC_FLAGS_RST;
    end
    else if (ce)
    begin
      internal_flags_r <= flag_update(warm_por_req ? ECC_FLAGS_RST : internal_flags_r,
                                      wr_internal, reg_wdata[1:0], internal_ecc_evt);
    end
  end

  // Register read data stand for one cycle only; unmapped words read zero.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= '0;
    end
    else if (ce)
    begin
      rdata_r <= '0;
      if (reg_rd)
      begin
        case (reg_addr)
          CONTROL_OFS:      rdata_r[2:0] <= control_r;
          STATUS_OFS:       rdata_r[1:0] <= {pend_r, subsys_reset_active};
          EVENT_OFS:        rdata_r[2:0] <= event_r;
          MASK_OFS:         rdata_r[2:0] <= mask_r;
          SHARED_ECC_OFS:   rdata_r[1:0] <= shared_flags_r;
          INTERNAL_ECC_OFS: rdata_r[1:0] <= internal_flags_r;
          ALARM_OFS:        rdata_r[1:0] <= {alarm_internal, alarm_shared};
          default:          rdata_r <= '0;
        endcase
      end
    end
  end

  // Outputs; alarms follow the retained flags, so the shared alarm outlives every soft reset and the internal one all but the warm reset.
  assign reg_rdata      = rdata_r;
  assign wake_accept    = wake_r;
  assign mtu_reset      = mtu_r;
  assign alarm_shared   = |shared_flags_r;
  assign alarm_internal = |internal_flags_r;
  assign irq            = |(event_r & mask_r);

  // Checks on the guarded behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_read_in_reset;
    ce && ram_rd && subsys_reset_active;
  endsequence

  a_read_blank: assert property (s_read_in_reset |=> ram_rdata == '0)
    else $error("Read during subsystem reset returned data.");
  // The array word must be untouched by a write taken during reset.
  a_write_drop: assert property (ce && ram_wr && subsys_reset_active
    |=> u_ram.mem[$past(ram_addr)] == $past(u_ram.mem[ram_addr]))
    else $error("Write reached the RAM during subsystem reset.");
  a_no_ecc_trigger: assert property (ce && !ecc_permit && !pend_r |=> !pend_r)
    else $error("ECC trigger armed without permit.");
  a_local_clear: assert property (begin_pulse && !soft_rst |=> !ecc_permit)
    else $error("ECC reset permit survived a local reset.");
  a_mtu_repeat: assert property (ce && pend_r && mtu_cnt_r == CNT_ZERO |=> mtu_reset)
    else $error("Memory test reset not repeated while trigger pending.");
  a_wake_gate: assert property (ce && ctrl_wake_req && !wake_permit |=> !wake_accept)
    else $error("Wake accepted without permit.");
  a_power_off: assert property (!power_enable |-> !begin_pulse)
    else $error("Subsystem reset began while powered off.");
  a_soft_retain: assert property (ce && (app_reset_req || sys_reset_req) && !wr_internal
    |=> (internal_flags_r & $past(internal_flags_r)) == $past(internal_flags_r))
    else $error("Internal RAM flags lost on soft reset.");
  a_warm_retain: assert property (ce && warm_por_req && !wr_shared
    |=> (shared_flags_r & $past(shared_flags_r)) == $past(shared_flags_r))
    else $error("Shared RAM flags lost on warm reset.");
  a_alarm_hold: assert property (alarm_shared && !(ce && wr_shared) |=> alarm_shared)
    else $error("Shared RAM alarm dropped without a clear.");
  a_flag_clear: assert property (ce && wr_shared && !reg_wdata[0] && !shared_ecc_evt[0]
    |=> !shared_flags_r[0])
    else $error("ECC flag not cleared by writing zero.");
  // The flag sets after a begin and only a clearing write may drop it next.
  a_flag_sticky: assert property (begin_pulse |=> event_r[EV_RESET_BIT] ##1
    (event_r[EV_RESET_BIT] || $past(wr_event && reg_wdata[EV_RESET_BIT])))
    else $error("Reset flag not held after reset start.");

endmodule
`default_nettype wire

// *** host_ram_master.sv ***
/*
  Behavioural host bus master that reads and writes the shared data RAM.
  Assumes the guard takes a strobe at a rising edge and answers a read
  one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module host_ram_master
(
  // Clock.
  input  wire logic                                 mclk,
  // Shared RAM port.
  output logic      [standby_guard_pkg::RAM_AW-1:0] ram_addr,
  output logic      [standby_guard_pkg::RAM_DW-1:0] ram_wdata,
  output logic                                      ram_wr,
  output logic                                      ram_rd,
  input  wire logic [standby_guard_pkg::RAM_DW-1:0] ram_rdata
);
  import standby_guard_pkg::*;

  // Idle bus at time zero.
  initial
  begin
    ram_addr  = '0;
    ram_wdata = '0;
    ram_wr    = 1'b0;
    ram_rd    = 1'b0;
  end

  // On release the lines are inverted, so a stale value never looks live.
  task automatic ram_write(input logic [RAM_AW-1:0] a, input logic [RAM_DW-1:0] d);
    @(posedge mclk);
    ram_wr    <= 1'b1;
    ram_addr  <= a;
    ram_wdata <= d;
    @(posedge mclk);
    ram_wr    <= 1'b0;
    ram_addr  <= ~a;
    ram_wdata <= ~d;
  endtask

  // Read data is taken once the answering edge has settled.
  task automatic ram_read(input logic [RAM_AW-1:0] a, output logic [RAM_DW-1:0] d);
    @(posedge mclk);
    ram_rd   <= 1'b1;
    ram_addr <= a;
    @(posedge mclk);
    ram_rd   <= 1'b0;
    ram_addr <= ~a;
    @(negedge mclk);
    d = ram_rdata;
  endtask
endmodule
`default_nettype wire

// *** standby_ram_reset_guard_tb.sv ***
/*
  Self-checking testbench for the standby RAM reset guard.
  Assumes the package and the host RAM master model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module standby_ram_reset_guard_tb;
  import standby_guard_pkg::*;
  logic        mclk, rst, ce, reg_wr, reg_rd, ram_wr, ram_rd;
  logic [7:0]  reg_addr, ram_addr;
  logic [31:0] reg_wdata, reg_rdata, ram_wdata, ram_rdata, got;
  logic [4:0]  req;
  logic [1:0]  sh_evt, in_evt;
  logic        active, wake, memory_test_unit, alarm_sh, alarm_in, irq;
  int          bad_count, compares, mtu_base, act_base, wk_base;
  int          mtu_cnt = 0, act_cnt = 0, wk_cnt = 0;

  standby_ram_reset_guard standby_ram_reset_guard_i
  (
    .mclk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ram_addr, .ram_wdata, .ram_wr, .ram_rd, .ram_rdata,
    .ctrl_reset_req(req[0]), .ctrl_wake_req(req[1]), .app_reset_req(req[2]),
    .sys_reset_req(req[3]), .warm_por_req(req[4]), .shared_ecc_evt(sh_evt),
    .internal_ecc_evt(in_evt), .subsys_reset_active(active), .wake_accept(wake),
    .mtu_reset(memory_test_unit), .alarm_shared(alarm_sh), .alarm_internal(alarm_in), .irq
  );
  host_ram_master host_ram_master_i (.mclk, .ram_addr, .ram_wdata, .ram_wr, .ram_rd, .ram_rdata);

  // Free-running clock, 100 ns period.
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Count pulses so short events are never missed between checks.
  always @(posedge mclk)
  begin
    mtu_cnt <= mtu_cnt + int'(memory_test_unit);
    act_cnt <= act_cnt + int'(active);
    wk_cnt  <= wk_cnt + int'(wake);
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, e);
  endtask
  // One-cycle request pulse on request line b.
  task automatic pulse(input int b);
    @(posedge mclk);
    req[b] <= 1'b1;
    @(posedge mclk);
    req <= 5'h00;
  endtask
  task automatic ecc(input logic [1:0] s, input logic [1:0] i);
    @(posedge mclk);
    sh_evt <= s;
    in_evt <= i;
    @(posedge mclk);
    sh_evt <= 2'h0;
    in_evt <= 2'h0;
  endtask
  // Counts are marked off the edge; only the counting process writes them.
  task automatic clr;
    @(negedge mclk);
    mtu_base = mtu_cnt;
    act_base = act_cnt;
    wk_base  = wk_cnt;
  endtask
  task automatic test_done;
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles.
  initial
  begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    test_done;
  end

  initial
  begin
    {rst, reg_wr, reg_rd, req, sh_evt, in_evt} = {1'b1, 11'h000};
    {reg_addr, reg_wdata} = '0;
    {bad_count, compares, mtu_base, act_base, wk_base} = '0;
    ce = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(CONTROL_OFS, 32'h3);
    rd_reg(STATUS_OFS, 32'h0);
    rd_reg(EVENT_OFS, 32'h0);
    rd_reg(8'h1c, 32'h0);
    host_ram_master_i.ram_write(8'h05, 32'ha5a50001);
    host_ram_master_i.ram_read(8'h05, got);
    chk(got, 32'ha5a50001);
    // Accesses while the subsystem is held in reset.
    pulse(0);
    host_ram_master_i.ram_write(8'h05, 32'h0bad0bad);
    host_ram_master_i.ram_read(8'h05, got);
    chk(got, 32'h0);
    rd_reg(EVENT_OFS, 32'h1);
    repeat (25) @(posedge mclk);
    host_ram_master_i.ram_read(8'h05, got);
    chk(got, 32'ha5a50001);
    rd_reg(EVENT_OFS, 32'h1);
    wr_reg(MASK_OFS, 32'h1);
    repeat (2) @(negedge mclk);
    chk(irq, 1'b1);
    // The host saw the flag after its write: clear it and repeat the write.
    wr_reg(EVENT_OFS, 32'h1);
    rd_reg(EVENT_OFS, 32'h0);
    chk(irq, 1'b0);
    host_ram_master_i.ram_write(8'h05, 32'h0bad0bad);
    rd_reg(EVENT_OFS, 32'h0);
    host_ram_master_i.ram_read(8'h05, got);
    chk(got, 32'h0bad0bad);
    // Enable low freezes all state, so this mask write must be ignored.
    @(posedge mclk);
    ce <= 1'b0;
    wr_reg(MASK_OFS, 32'h6);
    ce <= 1'b1;
    rd_reg(MASK_OFS, 32'h1);
    // Local reset clears the ECC permit.
    wr_reg(CONTROL_OFS, 32'h7);
    pulse(0);
    repeat (25) @(posedge mclk);
    rd_reg(CONTROL_OFS, 32'h3);
    clr;
    ecc(2'h2, 2'h0);
    repeat (30) @(posedge mclk);
    chk(act_cnt - act_base, 0);
    rd_reg(STATUS_OFS, 32'h0);
    // Power off with ECC permit: repeated test-unit resets, no subsystem reset.
    wr_reg(CONTROL_OFS, 32'h4);
    clr;
    pulse(0);
    ecc(2'h2, 2'h0);
    repeat (250) @(posedge mclk);
    chk(mtu_cnt - mtu_base, 3);
    chk(act_cnt - act_base, 0);
    rd_reg(STATUS_OFS, 32'h2);
    wr_reg(CONTROL_OFS, 32'h5);
    repeat (25) @(posedge mclk);
    rd_reg(STATUS_OFS, 32'h0);
    rd_reg(CONTROL_OFS, 32'h1);
    clr;
    pulse(1);
    repeat (3) @(posedge mclk);
    chk(wk_cnt - wk_base, 0);
    wr_reg(CONTROL_OFS, 32'h3);
    pulse(1);
    repeat (3) @(posedge mclk);
    chk(wk_cnt - wk_base, 1);
    // ECC flags across soft resets; the warm reset clears internal flags only.
    ecc(2'h1, 2'h3);
    for (int r = 2; r <= 4; r++)
    begin
      pulse(r);
      repeat (25) @(posedge mclk);
      rd_reg(SHARED_ECC_OFS, 32'h3);
      chk(alarm_sh, 1'b1);
      chk(alarm_in, (r < 4) ? 32'h1 : 32'h0);
      rd_reg(INTERNAL_ECC_OFS, (r < 4) ? 32'h3 : 32'h0);
    end
    wr_reg(SHARED_ECC_OFS, 32'h1);
    rd_reg(SHARED_ECC_OFS, 32'h1);
    wr_reg(SHARED_ECC_OFS, 32'h0);
    rd_reg(SHARED_ECC_OFS, 32'h0);
    chk(alarm_sh, 1'b0);
    test_done;
  end
endmodule
`default_nettype wire
